//--- pkg/wfs_pkg.sv
// Package: constants and types of the waveform sync and pulse control
package wfs_pkg;
    // Behaviour
    // - Autorange default; hold keeps present range
    // - Setup command forces autorange and output on
    // - Output off after power-on; lamp shows enable
    // - Overload raises error, disables output until re-enabled
    // - Normal polarity positive first; inverted negative
    // - Inversion about offset; sync never inverted
    // - Sync enabled by default; disabled drives low
    // - Sweep marker overrides the sync enable
    // - Square: sync copies programmed duty cycle
    // - Arbitrary: half-duty sync, high at first point
    // - Internal modulation: sync follows modulating half
    // - External modulation: sync from carrier halves
    // - Frequency shift: sync rises entering hop frequency
    // - Sweep without marker: high start, low midpoint
    // - Sweep with marker: low at marker frequency
    // - Triggered burst high until count done; infinite continuous
    // - Gated burst follows gate, finishes last cycle
    // - Sync enable kept in non-volatile storage
    // - Period 20 ns to 2000 s, default 1 ms
    // - Period covers width plus 1.6 edge
    // - Width 8 ns up, bounded by edge terms
    // - Edge 5 ns to 1 ms, at most 0.625 width

    localparam int AW = 6;
    localparam int TW = 41;

    // Register byte offsets
    localparam logic [AW-1:0] A_CTRL = 6'h00;
    localparam logic [AW-1:0] A_MODE = 6'h04;
    localparam logic [AW-1:0] A_STAT = 6'h08;
    localparam logic [AW-1:0] A_PERL = 6'h0C;
    localparam logic [AW-1:0] A_PERH = 6'h10;
    localparam logic [AW-1:0] A_WIDL = 6'h14;
    localparam logic [AW-1:0] A_WIDH = 6'h18;
    localparam logic [AW-1:0] A_EDGE = 6'h1C;

    // Control, mode and status field positions
    localparam int C_OUT = 0;
    localparam int C_AUTO = 1;
    localparam int C_INV = 2;
    localparam int C_SYNC = 3;
    localparam int C_SETUP = 4;
    localparam int C_MARK = 5;
    localparam int C_INF = 6;
    localparam int M_SHAPE = 0;
    localparam int M_MODE = 4;
    localparam int S_OUT = 0;
    localparam int S_ERR = 1;
    localparam int S_OVL = 2;
    localparam int S_SYNC = 3;
    localparam int S_RNG = 4;

    // Pulse timing limits and defaults, in nanoseconds
    localparam logic [TW-1:0] PER_MIN = 41'h14;
    localparam logic [TW-1:0] T_MAX = 41'h1D1A94A2000;
    localparam logic [TW-1:0] PER_RST = 41'hF4240;
    localparam logic [TW-1:0] WID_MIN = 41'h8;
    localparam logic [TW-1:0] WID_RST = 41'h186A0;
    localparam logic [TW-1:0] EDG_MIN = 41'h5;
    localparam logic [TW-1:0] EDG_MAX = 41'hF4240;
    localparam logic [TW-1:0] EDG_RST = 41'h5;

    localparam logic [1:0] RSP_OK = 2'h0;
    localparam logic [1:0] RSP_ERR = 2'h2;

    typedef enum logic [2:0] {
        SH_SINE, SH_SQUARE, SH_RAMP, SH_PULSE, SH_ARB, SH_NOISE, SH_DC
    } wfs_shape_t;

    typedef enum logic [2:0] {
        MD_CONT, MD_MODINT, MD_MODEXT, MD_FSK, MD_SWEEP, MD_BTRIG, MD_BGATE
    } wfs_mode_t;

    // Status levels and one-cycle events from the waveform engines
    typedef struct packed {
        logic wave_pos;
        logic arb_half;
        logic mod_half;
        logic car_half;
        logic hop;
        logic swp_start;
        logic swp_mid;
        logic marker_hit;
        logic bst_start;
        logic bst_done;
        logic cyc_end;
    } wfs_evt_t;
endpackage : wfs_pkg

//--- logic/wfs_ctrl.sv
`timescale 1ns/1ps
// Output stage control, sync marker generator and pulse timing clamp
module wfs_ctrl
    import wfs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire wfs_evt_t evt,
    input wire logic gate_pin,
    input wire logic ovl_pin,
    input wire logic [1:0] range_req,
    input wire logic nv_sync_en,
    output logic out_en,
    output logic led,
    output logic invert,
    output logic range_auto,
    output logic [1:0] range_sel,
    output logic sync_out,
    output logic nv_wr,
    output logic nv_data
);
    // Control and status state
    logic out_en_r, auto_r, inv_r, sync_en_r, mark_r, inf_r;
    wfs_shape_t shape_r;
    wfs_mode_t mode_r;
    logic err_r, sync_r, swp_r, bst_r, gq_r, load_r, nv_wr_r;
    logic [1:0] range_r;
    logic [TW-1:0] per_r, wid_r, edg_r;
    logic [31:0] per_lo_r, wid_lo_r;
    logic [2:0] ovl_s_r, gate_s_r;
    logic ovl_q_r, gate_q_r;

    // Bus slave state
    logic aw_ok_r, w_ok_r, bvalid_r, rvalid_r;
    logic [AW-1:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;

    // Register read view, shared by reads and byte-lane merging
    function automatic logic [31:0] rd_val(input logic [AW-1:0] a);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            A_CTRL: begin
                v[C_OUT] = out_en_r;
                v[C_AUTO] = auto_r;
                v[C_INV] = inv_r;
                v[C_SYNC] = sync_en_r;
                v[C_MARK] = mark_r;
                v[C_INF] = inf_r;
            end
            A_MODE: begin
                v[M_SHAPE+:3] = shape_r;
                v[M_MODE+:3] = mode_r;
            end
            A_STAT: begin
                v[S_OUT] = out_en_r;
                v[S_ERR] = err_r;
                v[S_OVL] = ovl_q_r;
                v[S_SYNC] = sync_r;
                v[S_RNG+:2] = range_r;
            end
            A_PERL: v = per_r[31:0];
            A_PERH: v[TW-33:0] = per_r[TW-1:32];
            A_WIDL: v = wid_r[31:0];
            A_WIDH: v[TW-33:0] = wid_r[TW-1:32];
            A_EDGE: v = edg_r[31:0];
            default: v = 32'h0;
        endcase
        return v;
    endfunction : rd_val

    function automatic logic map_ok(input logic [AW-1:0] a);
        return a inside {A_CTRL, A_MODE, A_STAT, A_PERL, A_PERH,
                         A_WIDL, A_WIDH, A_EDGE};
    endfunction : map_ok

    function automatic logic [TW-1:0] t_min(input logic [TW-1:0] a,
                                            input logic [TW-1:0] b);
        return (a < b) ? a : b;
    endfunction : t_min

    function automatic logic [TW-1:0] t_clamp(input logic [TW-1:0] a,
                                              input logic [TW-1:0] lo,
                                              input logic [TW-1:0] hi);
        return (a < lo) ? lo : ((a > hi) ? hi : a);
    endfunction : t_clamp

    // Scale a time by m/d, rounding up when asked
    function automatic logic [TW-1:0] t_md(input logic [TW-1:0] a,
                                           input logic [3:0] m,
                                           input logic [4:0] d,
                                           input logic up);
        logic [TW+3:0] t;
        t = {4'h0, a} * {{TW{1'b0}}, m};
        if (up) begin
            t = t + {{TW{1'b0}}, d[3:0]} - {{(TW+3){1'b0}}, 1'b1};
        end
        t = t / {{(TW-1){1'b0}}, d};
        return t[TW-1:0];
    endfunction : t_md

    // Pin synchronisers; a level counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ovl_s_r <= 3'h0;
            gate_s_r <= 3'h0;
            ovl_q_r <= 1'b0;
            gate_q_r <= 1'b0;
        end else begin
            ovl_s_r <= {ovl_s_r[1:0], ovl_pin};
            gate_s_r <= {gate_s_r[1:0], gate_pin};
            if (ovl_s_r[1] == ovl_s_r[2]) begin
                ovl_q_r <= ovl_s_r[2];
            end
            if (gate_s_r[1] == gate_s_r[2]) begin
                gate_q_r <= gate_s_r[2];
            end
        end
    end

    wire ovl_rise = (ovl_s_r[1] == ovl_s_r[2]) & ovl_s_r[2] & ~ovl_q_r;

    // Bus handshakes; one write and one read in flight
    assign s_axi_awready = ~aw_ok_r & ~bvalid_r;
    assign s_axi_wready = ~w_ok_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Write decode and byte-lane merge against the current value
    wire do_wr = aw_ok_r & w_ok_r;
    wire wr_hit = do_wr & map_ok(awaddr_r);
    wire [31:0] bmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                         {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    wire [31:0] wd = (rd_val(awaddr_r) & ~bmask) | (wdata_r & bmask);
    wire [31:0] w1c = wdata_r & bmask;
    wire w_ctrl = wr_hit & (awaddr_r == A_CTRL);
    wire w_mode = wr_hit & (awaddr_r == A_MODE);
    wire w_stat = wr_hit & (awaddr_r == A_STAT);
    wire w_perl = wr_hit & (awaddr_r == A_PERL);
    wire w_perh = wr_hit & (awaddr_r == A_PERH);
    wire w_widl = wr_hit & (awaddr_r == A_WIDL);
    wire w_widh = wr_hit & (awaddr_r == A_WIDH);
    wire w_edge = wr_hit & (awaddr_r == A_EDGE);
    wire w_setup = w_ctrl & w1c[C_SETUP];
    wire rd_go = s_axi_arvalid & ~rvalid_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bresp_r <= RSP_OK;
            rdata_r <= 32'h0;
            rresp_r <= RSP_OK;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_ok_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_ok_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_ok_r <= 1'b0;
                w_ok_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= map_ok(awaddr_r) ? RSP_OK : RSP_ERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (rd_go) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_val(s_axi_araddr);
                rresp_r <= map_ok(s_axi_araddr) ? RSP_OK : RSP_ERR;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Output enable: overload beats any enable in the same cycle
    wire out_en_nxt = ovl_rise | ovl_q_r ? 1'b0 :
                      w_setup ? 1'b1 :
                      w_ctrl ? wd[C_OUT] : out_en_r;

    // Range follows the request only while autoranging
    wire [1:0] range_nxt = auto_r ? range_req : range_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            out_en_r <= 1'b0;
            auto_r <= 1'b1;
            inv_r <= 1'b0;
            mark_r <= 1'b0;
            inf_r <= 1'b0;
            shape_r <= SH_SINE;
            mode_r <= MD_CONT;
            err_r <= 1'b0;
            range_r <= 2'h0;
        end else begin
            out_en_r <= out_en_nxt;
            range_r <= range_nxt;
            if (w_ctrl) begin
                auto_r <= wd[C_AUTO] | w_setup;
                inv_r <= wd[C_INV];
                mark_r <= wd[C_MARK];
                inf_r <= wd[C_INF];
            end
            if (w_mode) begin
                shape_r <= wfs_shape_t'(wd[M_SHAPE+:3]);
                mode_r <= wfs_mode_t'(wd[M_MODE+:3]);
            end
            // Sticky error, cleared by writing one; a new hit wins
            if (ovl_rise) begin
                err_r <= 1'b1;
            end else if (w_stat & w1c[S_ERR]) begin
                err_r <= 1'b0;
            end
        end
    end

    // Sync enable is restored from storage after every reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            load_r <= 1'b1;
            sync_en_r <= 1'b1;
            nv_wr_r <= 1'b0;
        end else begin
            load_r <= 1'b0;
            nv_wr_r <= w_ctrl;
            if (load_r) begin
                sync_en_r <= nv_sync_en;
            end else if (w_ctrl) begin
                sync_en_r <= wd[C_SYNC];
            end
        end
    end

    // Sweep, burst and gate marker states
    wire swp_nxt = evt.swp_start ? 1'b1 :
                   (mark_r ? evt.marker_hit : evt.swp_mid) ? 1'b0 :
                   swp_r;
    wire bst_nxt = evt.bst_start ? 1'b1 :
                   evt.bst_done ? 1'b0 : bst_r;
    wire gq_nxt = gate_q_r ? 1'b1 :
                  evt.cyc_end ? 1'b0 : gq_r;

    // Continuous-mode sync source; no sync for noise or dc
    logic cont_src, sync_src;
    always_comb begin
        unique case (shape_r)
            SH_SINE, SH_RAMP, SH_PULSE: cont_src = evt.wave_pos;
            SH_SQUARE: cont_src = evt.wave_pos;
            SH_ARB: cont_src = evt.arb_half;
            default: cont_src = 1'b0;
        endcase
    end

    // Polarity never enters here, so the sync keeps its sense
    always_comb begin
        unique case (mode_r)
            MD_CONT: sync_src = cont_src;
            MD_MODINT: sync_src = evt.mod_half;
            MD_MODEXT: sync_src = evt.car_half;
            MD_FSK: sync_src = evt.hop;
            MD_SWEEP: sync_src = swp_nxt;
            MD_BTRIG: sync_src = inf_r ? cont_src : bst_nxt;
            MD_BGATE: sync_src = gq_nxt;
            default: sync_src = 1'b0;
        endcase
    end

    wire mark_on = (mode_r == MD_SWEEP) & mark_r;
    wire sync_nxt = (sync_en_r | mark_on) & sync_src;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            swp_r <= 1'b0;
            bst_r <= 1'b0;
            gq_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            swp_r <= swp_nxt;
            bst_r <= bst_nxt;
            gq_r <= gq_nxt;
            sync_r <= sync_nxt;
        end
    end

    // Pulse timing clamp; high-word writes commit the staged low word
    logic [TW-1:0] per_nxt, wid_nxt, edg_nxt, t_new, cap;
    always_comb begin
        per_nxt = per_r;
        wid_nxt = wid_r;
        edg_nxt = edg_r;
        t_new = '0;
        cap = '0;
        if (w_perh) begin
            t_new = t_clamp({wd[TW-33:0], per_lo_r}, PER_MIN, T_MAX);
            per_nxt = t_new;
            edg_nxt = t_min(edg_r, t_md(t_new, 4'h5, 5'h10, 1'b0));
            wid_nxt = t_min(wid_r,
                            t_new - t_md(edg_nxt, 4'h8, 5'h05, 1'b1));
            // Rounding in the width cut can leave the edge too long; trim
            edg_nxt = t_min(edg_nxt, t_md(wid_nxt, 4'h5, 5'h08, 1'b0));
        end else if (w_widh) begin
            t_new = t_clamp({wd[TW-33:0], wid_lo_r}, WID_MIN, T_MAX);
            wid_nxt = t_min(t_new,
                            per_r - t_md(edg_r, 4'h8, 5'h05, 1'b1));
            edg_nxt = t_min(edg_r, t_md(wid_nxt, 4'h5, 5'h08, 1'b0));
        end else if (w_edge) begin
            t_new = t_clamp({9'h0, wd}, EDG_MIN, EDG_MAX);
            cap = t_min(wid_r, per_r - wid_r);
            edg_nxt = t_min(t_new, t_md(cap, 4'h5, 5'h08, 1'b0));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            per_r <= PER_RST;
            wid_r <= WID_RST;
            edg_r <= EDG_RST;
            per_lo_r <= 32'h0;
            wid_lo_r <= 32'h0;
        end else begin
            per_r <= per_nxt;
            wid_r <= wid_nxt;
            edg_r <= edg_nxt;
            if (w_perl) begin
                per_lo_r <= wd;
            end
            if (w_widl) begin
                wid_lo_r <= wd;
            end
        end
    end

    assign out_en = out_en_r;
    assign led = out_en_r;
    assign invert = inv_r;
    assign range_auto = auto_r;
    assign range_sel = range_r;
    assign sync_out = sync_r;
    assign nv_wr = nv_wr_r;
    assign nv_data = sync_en_r;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_hold; !auto_r |=> $stable(range_r); endproperty
    a_hold: assert property (p_hold) else $error("range moved in hold");
    property p_setup; w_setup && !ovl_q_r && !ovl_rise
        |=> out_en_r && auto_r; endproperty
    a_setup: assert property (p_setup) else $error("setup ignored");
    property p_pwr; $past(sys_rst) |-> !out_en_r && led == out_en_r;
    endproperty
    a_pwr: assert property (p_pwr) else $error("output on at start");
    property p_ovl; ovl_rise |=> !out_en_r && err_r ##1 !out_en_r;
    endproperty
    a_ovl: assert property (p_ovl) else $error("overload not handled");
    property p_inv; w_ctrl |=> invert == $past(wd[C_INV]); endproperty
    a_inv: assert property (p_inv) else $error("polarity not set");
    property p_wave; mode_r == MD_CONT && shape_r == SH_SINE && sync_en_r
        |=> sync_r == $past(evt.wave_pos); endproperty
    a_wave: assert property (p_wave) else $error("sine sync wrong");
    property p_off; !sync_en_r && !mark_on |=> !sync_r; endproperty
    a_off: assert property (p_off) else $error("sync not low");
    property p_mark; mark_on && evt.marker_hit && !evt.swp_start
        |=> !sync_r; endproperty
    a_mark: assert property (p_mark) else $error("marker not low");
    property p_swp; mode_r == MD_SWEEP && evt.swp_start
        && (sync_en_r || mark_r) |=> sync_r; endproperty
    a_swp: assert property (p_swp) else $error("sweep start lost");
    property p_mod; mode_r == MD_MODINT && sync_en_r
        |=> sync_r == $past(evt.mod_half); endproperty
    a_mod: assert property (p_mod) else $error("mod sync wrong");
    property p_gate; mode_r == MD_BGATE && sync_en_r && gq_r
        && !evt.cyc_end |=> sync_r; endproperty
    a_gate: assert property (p_gate) else $error("gate sync dropped");
    // Widened by four bits so five times the longest period cannot wrap
    property p_fit; 5 * {4'h0, wid_r} + 8 * {4'h0, edg_r} <= 5 * {4'h0, per_r}
        && 8 * {4'h0, edg_r} <= 5 * {4'h0, wid_r}; endproperty
    a_fit: assert property (p_fit) else $error("pulse timing broken");
    property p_nv; load_r |=> sync_en_r == $past(nv_sync_en); endproperty
    a_nv: assert property (p_nv) else $error("sync enable not restored");

    c_ovl: cover property (ovl_rise ##1 w_ctrl ##1 out_en_r);
    c_mark: cover property (mark_on && evt.swp_start ##[1:50] !sync_r);
    c_gate: cover property (gq_r && !gate_q_r ##1 !gq_r);
endmodule : wfs_ctrl

//--- tb/wfs_sync_rx.sv
`timescale 1ns/1ps
// Model of the test equipment that receives the sync marker
module wfs_sync_rx (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sync_in,
    output logic [15:0] rise_cnt
);
    logic last_r;

    // Count rising edges; a level input only, so one sample per cycle
    always_ff @(posedge sys_clk) begin
        last_r <= sys_rst ? 1'b0 : sync_in;
        if (sys_rst) rise_cnt <= 16'h0;
        else if (sync_in && !last_r) rise_cnt <= rise_cnt + 16'h1;
    end
endmodule : wfs_sync_rx

//--- tb/tb_top.sv
`timescale 1ns/1ps
// Testbench: register bus, output control, sync marker and pulse clamps
module tb_top;
    import wfs_pkg::*;
    logic sys_clk = 1'b0, sys_rst = 1'b1;
    logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, gate_pin = 0, ovl_pin = 0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, out_en, led, invert, range_auto, sync_out, nv_wr;
    logic nv_data, nv_sync_en = 1'b1;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, range_sel, range_req = 2'h0;
    logic [15:0] rise_cnt, n0;
    logic [31:0] seed = 32'h3F06;
    wfs_evt_t evt = '0, e;
    int n_errors = 0, total_checks = 0, m, s;
    int n_nvw = 0;

    wfs_ctrl dut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .evt, .gate_pin,
        .ovl_pin, .range_req, .nv_sync_en, .out_en, .led, .invert,
        .range_auto, .range_sel, .sync_out, .nv_wr, .nv_data);
    wfs_sync_rx rx (.sys_clk, .sys_rst, .sync_in(sync_out), .rise_cnt);

    // 20 MHz clock
    always #25 sys_clk = ~sys_clk;

    // Count store requests; each pulse stands for one cycle only
    always @(posedge sys_clk) begin
        if (nv_wr === 1'b1) n_nvw++;
    end

    task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
        total_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Expected marker level for the level-following modes
    function logic esync(input int m, input int s, input wfs_evt_t e);
        if (m == 1) return e.mod_half;
        if (m == 2) return e.car_half;
        if (m == 3) return e.hop;
        if (s == 4) return e.arb_half;
        return (s < 4) ? e.wave_pos : 1'b0;
    endfunction : esync

    // Write: both channels offered at once, bready held until the answer
    task axw(input logic [AW-1:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            t++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && t < 64);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
        if (t >= 64) n_errors++;
    endtask : axw

    task axr(input logic [AW-1:0] a);
        int t;
        t = 0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            t++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && t < 64);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        if (t >= 64) n_errors++;
    endtask : axr

    // Present events for one cycle, then look at the marker one edge later
    task sy(input wfs_evt_t ev, input logic ex);
        @(posedge sys_clk);
        evt <= ev;
        @(posedge sys_clk);
        evt <= '0;
        #1;
        chk("sync", sync_out, ex);
    endtask : sy

    task end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim

    // Watchdog: the tests need some 450 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        axr(A_CTRL);
        chk("ctrl", rd, 32'h0000000A);
        chk("led", led, 0);
        axr(A_PERL);
        chk("period", rd, 32'h000F4240);
        axr(A_EDGE);
        chk("edge", rd, 32'h00000005);
        $display("test defaults done");
        axw(A_CTRL, 32'h0B);
        chk("led", led, 1);
        chk("nv", nv_data, 1);
        ovl_pin <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk("out", out_en, 0);
        chk("nvwr", n_nvw, 1);
        axw(A_CTRL, 32'h0B);
        chk("out", out_en, 0);
        axr(A_STAT);
        chk("ovl", rd[1], 1);
        ovl_pin <= 1'b0;
        repeat (8) @(posedge sys_clk);
        axw(A_CTRL, 32'h0B);
        chk("out", out_en, 1);
        $display("test overload done");
        range_req <= 2'h2;
        repeat (4) @(posedge sys_clk);
        chk("range", range_sel, 2);
        axw(A_CTRL, 32'h08);
        range_req <= 2'h1;
        repeat (4) @(posedge sys_clk);
        chk("range", range_sel, 2);
        axw(A_CTRL, 32'h18);
        chk("out", out_en, 1);
        chk("auto", range_auto, 1);
        repeat (4) @(posedge sys_clk);
        chk("range", range_sel, 1);
        axw(A_CTRL, 32'h0F);
        chk("inv", invert, 1);
        sy(11'h400, 1);
        sy(11'h000, 0);
        $display("test range polarity done");
        // Level-following modes with random engine states
        for (int k = 0; k < 10; k++) begin
            m = (k < 7) ? 0 : k - 6;
            s = (k < 7) ? k : 0;
            axw(A_MODE, 32'(m * 16 + s));
            repeat (8) begin
                e = wfs_evt_t'(11'(xs()));
                sy(e, esync(m, s, e));
            end
        end
        axw(A_MODE, 32'h00);
        axw(A_CTRL, 32'h03);
        sy(11'h400, 0);
        chk("nv", nv_data, 0);
        $display("test level modes done");
        axw(A_MODE, 32'h40);
        n0 = rise_cnt;
        sy(11'h020, 0);
        axw(A_CTRL, 32'h0B);
        sy(11'h020, 1);
        sy(11'h000, 1);
        sy(11'h010, 0);
        chk("rises", rise_cnt - n0, 1);
        axw(A_CTRL, 32'h23);
        sy(11'h020, 1);
        sy(11'h010, 1);
        sy(11'h008, 0);
        axw(A_MODE, 32'h50);
        axw(A_CTRL, 32'h0B);
        sy(11'h004, 1);
        sy(11'h000, 1);
        sy(11'h002, 0);
        axw(A_CTRL, 32'h4B);
        sy(11'h400, 1);
        sy(11'h000, 0);
        axw(A_MODE, 32'h60);
        axw(A_CTRL, 32'h0B);
        gate_pin <= 1'b1;
        repeat (7) @(posedge sys_clk);
        chk("gate", sync_out, 1);
        gate_pin <= 1'b0;
        repeat (7) @(posedge sys_clk);
        chk("gate", sync_out, 1);
        sy(11'h001, 0);
        $display("test event modes done");
        // Mid-run reset: output off again, sync enable from storage
        @(posedge sys_clk);
        nv_sync_en <= 1'b0;
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        axr(A_CTRL);
        chk("ctrl", rd, 32'h00000002);
        chk("nv", nv_data, 0);
        $display("test reset done");
        axw(A_PERL, 32'd10);
        axw(A_PERH, 32'h0);
        axr(A_PERL);
        chk("period", rd, 32'd20);
        axr(A_WIDL);
        chk("width", rd, 32'd12);
        axw(A_WIDL, 32'd4);
        axw(A_WIDH, 32'h0);
        axr(A_WIDL);
        chk("width", rd, 32'd8);
        axw(A_EDGE, 32'd100);
        axr(A_EDGE);
        chk("edge", rd, 32'd5);
        axw(A_PERL, 32'h0);
        axw(A_PERH, 32'h1FF);
        axr(A_PERH);
        chk("period", rd, 32'h1D1);
        axw(6'h20, 32'h0);
        chk("bresp", rsp, RSP_ERR);
        axr(6'h20);
        chk("rresp", rsp, RSP_ERR);
        $display("test clamps done");
        end_sim();
    end
endmodule : tb_top
